// file: hw/acfg_bank.sv
// Configuration bank for the auxiliary I/O and power-management devices.
`timescale 1ns/1ps
`default_nettype none
module acfg_bank (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic hard_rst_i,
	input wire logic vcc_por_i,
	input wire logic vtr_por_i,
	input wire logic io_sel_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic floppy_rate_wr_i,
	input wire logic serial_port_a_fcr_wr_i,
	input wire logic serial_port_b_fcr_wr_i,
	input wire logic [7:0] shadow_data_i,
	input wire logic wdt_expired_i,
	input wire logic sci_event_i,
	output logic [7:0] io_rdata_o,
	output logic [7:0] ldn_o,
	output logic soft_rst_o,
	output logic global_config_reg_22_b5_o,
	output logic aux_active_o,
	output logic pm_active_o,
	output logic [15:0] pm_block_base_o,
	output logic [7:0] pm_irq_sel_o,
	output logic [7:0] sleep_wake_o,
	output logic wdt_status_o,
	output logic wdt_force_o,
	output logic sci_o
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0] index;
	logic [7:0] ldn;
	logic soft_rst;
	logic global_config_reg_22_b5;
	logic wdt_stat;
	logic wdt_force;
	logic sci;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic [7:0] tbl_rdata;
	logic [2:0] pin_rst;
	logic [2:0] rst_s;
	logic hard_s;
	logic vcc_s;
	logic vtr_s;
	logic main_rst;
	logic data_wr;
	logic data_rd;
	logic aux_sel;
	logic wdt_we;
	logic [acfg_pkg::NREG-1:0] tbl_we;
	logic [acfg_pkg::NREG-1:0] tbl_hit;
	logic [7:0] regq [acfg_pkg::NREG];
	logic [acfg_pkg::NSHADOW-1:0] sh_wr;
	logic [7:0] shadow [acfg_pkg::NSHADOW];
	logic [acfg_pkg::NSHADOW-1:0] sh_hit;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	// ------------------------------------------------------------
	// Reset pins
	// ------------------------------------------------------------
	assign pin_rst = {vtr_por_i, vcc_por_i, hard_rst_i};

	for (genvar g = 0; g < 3; g++) begin : g_sync
		acfg_sync u_sync (
			.clock_i(clock_i),
			.rst_n_i(rst_n_i),
			.d_i(pin_rst[g]),
			.q_o(rst_s[g])
		);
	end

	assign hard_s = rst_s[0];
	assign vcc_s = rst_s[1];
	assign vtr_s = rst_s[2];
	assign main_rst = hard_s || vcc_s;

	// ------------------------------------------------------------
	// Index and data ports
	// ------------------------------------------------------------
	assign data_wr = io_wr_i && (io_sel_i == acfg_pkg::PORT_DATA);
	assign data_rd = io_rd_i && (io_sel_i == acfg_pkg::PORT_DATA);
	assign aux_sel = (ldn == acfg_pkg::LDN_AUX);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			index <= acfg_pkg::RST_ZERO;
		end else if (main_rst) begin
			index <= acfg_pkg::RST_ZERO;
		end else if (io_wr_i && (io_sel_i == acfg_pkg::PORT_INDEX)) begin
			index <= io_wdata_i;
		end
	end

	// The selected device number steers every later device-level access.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ldn <= acfg_pkg::RST_ZERO;
		end else if (main_rst) begin
			ldn <= acfg_pkg::RST_ZERO;
		end else if (data_wr && index == acfg_pkg::IDX_LDN) begin
			ldn <= io_wdata_i;
		end
	end

	// ------------------------------------------------------------
	// Soft reset and global register 22
	// ------------------------------------------------------------
	// Held for exactly one cycle, so the bit clears itself.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= data_wr && index == acfg_pkg::IDX_CFG_CTRL
				&& io_wdata_i[acfg_pkg::SOFT_RST_BIT];
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			global_config_reg_22_b5 <= acfg_pkg::GLOBAL_CONFIG_REG_22_RST;
		end else if (vtr_s) begin
			global_config_reg_22_b5 <= acfg_pkg::GLOBAL_CONFIG_REG_22_RST;
		end else if (data_wr && index == acfg_pkg::IDX_GLOBAL_CONFIG_REG_22) begin
			global_config_reg_22_b5 <= io_wdata_i[acfg_pkg::GLOBAL_CONFIG_REG_22_BIT];
		end
	end

	// ------------------------------------------------------------
	// Device register table
	// ------------------------------------------------------------
	for (genvar i = 0; i < acfg_pkg::NREG; i++) begin : g_reg
		assign tbl_hit[i] = (index == acfg_pkg::OFS[i])
			&& (ldn == acfg_pkg::LDN_AUX || ldn == acfg_pkg::LDN_PM)
			&& ((i < acfg_pkg::T_PM_ACT) == aux_sel);
		assign tbl_we[i] = data_wr && tbl_hit[i];
		acfg_reg #(
			.RST_VAL(acfg_pkg::RSTV[i]),
			.CLASS(acfg_pkg::CLS[i])
		) u_reg (
			.clock_i(clock_i),
			.rst_n_i(rst_n_i),
			.hard_i(hard_s),
			.vcc_i(vcc_s),
			.vtr_i(vtr_s),
			.soft_i(soft_rst),
			.we_i(tbl_we[i]),
			.wdata_i(io_wdata_i),
			.q_o(regq[i])
		);
	end

	// ------------------------------------------------------------
	// Shadows of write-only registers elsewhere in the chip
	// ------------------------------------------------------------
	assign sh_wr = {serial_port_b_fcr_wr_i, serial_port_a_fcr_wr_i, floppy_rate_wr_i};

	// No reset at all: a shadow read before its first capture is undefined.
	for (genvar s = 0; s < acfg_pkg::NSHADOW; s++) begin : g_shadow
		assign sh_hit[s] = aux_sel && index == acfg_pkg::SHADOW_IDX[s];
		always_ff @(posedge clock_i) begin
			if (sh_wr[s]) begin
				shadow[s] <= shadow_data_i;
			end
		end
	end

	// ------------------------------------------------------------
	// Watchdog control: status reads only, force and clear write only
	// ------------------------------------------------------------
	assign wdt_we = data_wr && aux_sel && index == acfg_pkg::IDX_WATCHDOG_CONTROL_REG;

	// A new expiry in the cycle of a clear keeps the status set.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wdt_stat <= 1'b0;
		end else if (main_rst || vtr_s) begin
			wdt_stat <= 1'b0;
		end else if (wdt_expired_i) begin
			wdt_stat <= 1'b1;
		end else if (wdt_we && io_wdata_i[acfg_pkg::WDT_CLR_BIT]) begin
			wdt_stat <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wdt_force <= 1'b0;
		end else begin
			wdt_force <= wdt_we && io_wdata_i[acfg_pkg::WDT_FORCE_BIT];
		end
	end

	// ------------------------------------------------------------
	// Power-management interrupt
	// ------------------------------------------------------------
	// The event is passed on whatever the activate byte holds.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sci <= 1'b0;
		end else begin
			sci <= sci_event_i;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		tbl_rdata = acfg_pkg::RST_ZERO;
		for (int k = 0; k < acfg_pkg::NREG; k++) begin
			if (tbl_hit[k]) begin
				tbl_rdata = tbl_rdata | regq[k];
			end
		end
		for (int k = 0; k < acfg_pkg::NSHADOW; k++) begin
			if (sh_hit[k]) begin
				tbl_rdata = tbl_rdata | shadow[k];
			end
		end
	end

	always_comb begin
		next_rdata = acfg_pkg::RST_ZERO;
		if (io_sel_i == acfg_pkg::PORT_INDEX) begin
			next_rdata = index;
		end else if (index == acfg_pkg::IDX_CFG_CTRL) begin
			next_rdata[acfg_pkg::SOFT_RST_BIT] = soft_rst;
		end else if (index == acfg_pkg::IDX_LDN) begin
			next_rdata = ldn;
		end else if (index == acfg_pkg::IDX_DEV_ID) begin
			next_rdata = acfg_pkg::DEV_ID_VAL;
		end else if (index == acfg_pkg::IDX_GLOBAL_CONFIG_REG_22) begin
			next_rdata[acfg_pkg::GLOBAL_CONFIG_REG_22_BIT] = global_config_reg_22_b5;
		end else if (aux_sel && index == acfg_pkg::IDX_WATCHDOG_CONTROL_REG) begin
			next_rdata[acfg_pkg::WDT_STAT_BIT] = wdt_stat;
		end else begin
			next_rdata = tbl_rdata;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata <= acfg_pkg::RST_ZERO;
		end else if (io_rd_i) begin
			rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign io_rdata_o = rdata;
	assign ldn_o = ldn;
	assign soft_rst_o = soft_rst;
	assign global_config_reg_22_b5_o = global_config_reg_22_b5;
	assign aux_active_o = regq[acfg_pkg::T_AUX_ACT][0];
	assign pm_active_o = regq[acfg_pkg::T_PM_ACT][0];
	assign pm_block_base_o = {regq[acfg_pkg::T_PM_HI], regq[acfg_pkg::T_PM_LO]};
	assign pm_irq_sel_o = regq[acfg_pkg::T_PM_IRQ];
	assign sleep_wake_o = regq[acfg_pkg::T_PM_SLEEP];
	assign wdt_status_o = wdt_stat;
	assign wdt_force_o = wdt_force;
	assign sci_o = sci;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// A reset in the cycle of the write legally wins, so it is left out.
	sequence s_wr_hi;
		data_wr && ldn == acfg_pkg::LDN_PM && index == acfg_pkg::OFS[acfg_pkg::T_PM_HI]
			&& !main_rst && !vtr_s && !soft_rst;
	endsequence

	sequence s_wr_lo;
		data_wr && ldn == acfg_pkg::LDN_PM && index == acfg_pkg::OFS[acfg_pkg::T_PM_LO]
			&& !main_rst && !vtr_s && !soft_rst;
	endsequence

	sequence s_floppy_cap;
		floppy_rate_wr_i ##1 !floppy_rate_wr_i;
	endsequence

	sequence s_floppy_read;
		data_rd && aux_sel && index == acfg_pkg::SHADOW_IDX[0] && !floppy_rate_wr_i;
	endsequence

	sequence s_soft_req;
		data_wr && index == acfg_pkg::IDX_CFG_CTRL && io_wdata_i[acfg_pkg::SOFT_RST_BIT];
	endsequence

	AST_BASE_HIGH: assert property (s_wr_hi |=> pm_block_base_o[15:8] == $past(io_wdata_i))
		else $error("Base high byte not taken from index 60h.");

	AST_BASE_LOW: assert property (s_wr_lo |=> pm_block_base_o[7:0] == $past(io_wdata_i))
		else $error("Base low byte not taken from index 61h.");

	AST_STANDBY_KEEP: assert property ((main_rst || vtr_s || soft_rst)
		&& !tbl_we[acfg_pkg::T_STBY] |=> $stable(regq[acfg_pkg::T_STBY]))
		else $error("Standby register disturbed by a non-battery reset.");

	AST_SCI_UNGATED: assert property (sci_event_i && !pm_active_o |=> sci_o)
		else $error("SCI lost while the device is deactivated.");

	AST_GLOBAL22_HOLD: assert property ((main_rst || soft_rst) && !vtr_s
		&& !(data_wr && index == acfg_pkg::IDX_GLOBAL_CONFIG_REG_22)
		|=> $stable(global_config_reg_22_b5))
		else $error("Register 22 bit 5 changed by a reset other than standby.");

	AST_WDT_MIXED: assert property (data_rd && aux_sel && index == acfg_pkg::IDX_WATCHDOG_CONTROL_REG
		|=> io_rdata_o[7:1] == 7'h00)
		else $error("Write-only watchdog bits visible on read.");

	AST_SHADOW: assert property (s_floppy_cap ##0 s_floppy_read
		|=> io_rdata_o == $past(shadow_data_i, 2))
		else $error("Floppy rate shadow does not return the last write.");

	AST_WP_CLEAR: assert property (main_rst |=> regq[acfg_pkg::T_WP] == 8'h00)
		else $error("Write-protect force not cleared by hard or main reset.");

	AST_WP_KEEP: assert property ((vtr_s || soft_rst) && !main_rst
		&& !tbl_we[acfg_pkg::T_WP] |=> $stable(regq[acfg_pkg::T_WP]))
		else $error("Write-protect force changed by standby or soft reset.");

	AST_LDN_SELECT: assert property (data_wr && index == acfg_pkg::OFS[acfg_pkg::T_AUX_ACT]
		&& ldn == acfg_pkg::LDN_PM && !main_rst && !vtr_s && !soft_rst
		|=> $stable(aux_active_o))
		else $error("Activate write reached a device that is not selected.");

	AST_SOFT_PULSE: assert property (s_soft_req |=> soft_rst ##1 !soft_rst)
		else $error("Soft reset did not pulse and clear itself.");

	AST_UNMAPPED: assert property (data_rd && index == acfg_pkg::IDX_UNUSED
		|=> io_rdata_o == 8'h00)
		else $error("Unmapped index did not read zero.");

	AST_WDT_SOFT: assert property (soft_rst && !main_rst && !vtr_s
		&& !tbl_we[acfg_pkg::T_WATCHDOG_UNITS]
		|=> $stable(regq[acfg_pkg::T_WATCHDOG_UNITS]))
		else $error("Watchdog units changed by soft reset.");

	AST_WDT_CLEAR: assert property (main_rst || vtr_s
		|=> regq[acfg_pkg::T_WATCHDOG_UNITS] == 8'h00 && !wdt_status_o)
		else $error("Watchdog setup not cleared by hard or supply reset.");
endmodule
`default_nettype wire

// file: hw/acfg_pkg.sv
// Constants for the auxiliary I/O and power-management configuration bank.
// How it works
// - Block base split: high byte 60h, low 61h.
// - Standby registers reset only by battery reset.
// - Activate bit never gates SCI generation.
// - Config reg 22 bit 5: standby reset only.
// - Watchdog control mixes read-only and write-only bits.
// - C2h-C4h shadow last write-only values, unreset.
// - Write-protect force clears on hard/main reset.
// - Index 07h selects device for later accesses.
// - Bit 0 of 02h soft resets, self clears.
// - Unmapped indices ignore writes, read zero.
package acfg_pkg;

	// ------------------------------------------------------------
	// Host port and global indices
	// ------------------------------------------------------------
	localparam logic PORT_INDEX = 1'b0;
	localparam logic PORT_DATA = 1'b1;
	localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
	localparam logic [7:0] IDX_LDN = 8'h07;
	localparam logic [7:0] IDX_DEV_ID = 8'h20;
	localparam logic [7:0] IDX_GLOBAL_CONFIG_REG_22 = 8'h22;
	localparam logic [7:0] IDX_UNUSED = 8'h00;
	localparam int SOFT_RST_BIT = 0;
	localparam int GLOBAL_CONFIG_REG_22_BIT = 5;
	localparam logic GLOBAL_CONFIG_REG_22_RST = 1'b0;
	// Arbitrary identification value.
	localparam logic [7:0] DEV_ID_VAL = 8'h5A;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// ------------------------------------------------------------
	// Logical devices and special device indices
	// ------------------------------------------------------------
	localparam logic [7:0] LDN_AUX = 8'h08;
	localparam logic [7:0] LDN_PM = 8'h0A;
	localparam int NSHADOW = 3;
	localparam logic [7:0] SHADOW_IDX [NSHADOW] = '{8'hC2, 8'hC3, 8'hC4};
	localparam logic [7:0] IDX_WATCHDOG_CONTROL_REG = 8'hF4;
	localparam int WDT_STAT_BIT = 0;
	localparam int WDT_FORCE_BIT = 1;
	localparam int WDT_CLR_BIT = 2;

	// ------------------------------------------------------------
	// Reset classes: hard, main supply, standby supply, soft
	// ------------------------------------------------------------
	localparam int CLS_HARD = 3;
	localparam int CLS_VCC = 2;
	localparam int CLS_VTR = 1;
	localparam int CLS_SOFT = 0;

	// ------------------------------------------------------------
	// Register table
	// ------------------------------------------------------------
	localparam int NREG = 43;
	localparam int T_AUX_ACT = 0;
	localparam int T_STBY = 2;
	localparam int T_WP = 8;
	localparam int T_WATCHDOG_UNITS = 32;
	localparam int T_PM_ACT = 38;
	localparam int T_PM_HI = 39;
	localparam int T_PM_LO = 40;
	localparam int T_PM_IRQ = 41;
	localparam int T_PM_SLEEP = 42;
	localparam logic [7:0] OFS [NREG] = '{
		8'h30, 8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB8, 8'hC0, 8'hC1, 8'hC5, 8'hC6,
		8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5,
		8'hD6, 8'hD7, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hE6, 8'hE7,
		8'hEF, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF6, 8'hF9, 8'hFA,
		8'h30, 8'h60, 8'h61, 8'h70, 8'hF0};
	localparam logic [7:0] RSTV [NREG] = '{
		8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
		8'h01, 8'h09, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
		8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [3:0] CLS [NREG] = '{
		4'hF, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h0, 4'hC, 4'hC, 4'h0,
		4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
		4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
		4'h0, 4'h0, 4'hE, 4'hE, 4'hE, 4'h0, 4'h0, 4'h0,
		4'hF, 4'hF, 4'hF, 4'h0, 4'h0};

endpackage

// file: hw/acfg_sync.sv
// Three-stage synchroniser for a reset pin.
`timescale 1ns/1ps
`default_nettype none
module acfg_sync (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic d_i,
	output logic q_o
);
	logic [2:0] stage;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage <= 3'h0;
		end else begin
			stage <= {stage[1:0], d_i};
		end
	end

	// A change only counts once the second and third stages agree.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_o <= 1'b0;
		end else if (stage[1] == stage[2]) begin
			q_o <= stage[2];
		end
	end
endmodule
`default_nettype wire

// file: hw/acfg_reg.sv
// One configuration byte with its own set of reset sources.
`timescale 1ns/1ps
`default_nettype none
module acfg_reg #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [3:0] CLASS = 4'h0
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic hard_i,
	input wire logic vcc_i,
	input wire logic vtr_i,
	input wire logic soft_i,
	input wire logic we_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] q_o
);
	logic class_rst;

	assign class_rst = (CLASS[acfg_pkg::CLS_HARD] && hard_i)
		|| (CLASS[acfg_pkg::CLS_VCC] && vcc_i)
		|| (CLASS[acfg_pkg::CLS_VTR] && vtr_i)
		|| (CLASS[acfg_pkg::CLS_SOFT] && soft_i);

	// The asynchronous reset is the battery power-on reset; it is the only one
	// that reaches standby registers, whose class holds no other source.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_o <= RST_VAL;
		end else if (class_rst) begin
			q_o <= RST_VAL;
		end else if (we_i) begin
			q_o <= wdata_i;
		end
	end
endmodule
`default_nettype wire

// file: dv/acfg_host.sv
// Host processor model that drives the index and data ports of the bank.
`timescale 1ns/1ps
`default_nettype none
module acfg_host (
	input wire logic clock_i,
	input wire logic [7:0] rdata_i,
	output logic sel_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o
);
	initial begin
		sel_o = 1'b0;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end

	// ------------------------------------------------------------
	// Port cycles
	// ------------------------------------------------------------
	// Released data lines show the inverse, so a stale byte can never pass for a write.
	task automatic cyc(input logic sel, input logic wr, input logic [7:0] d);
		@(posedge clock_i);
		sel_o <= sel;
		wr_o <= wr;
		rd_o <= !wr;
		wdata_o <= d;
		@(posedge clock_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		wdata_o <= ~d;
	endtask

	task automatic acc(input logic [7:0] idx, input logic wr, input logic [7:0] d,
		output logic [7:0] q);
		cyc(acfg_pkg::PORT_INDEX, 1'b1, idx);
		cyc(acfg_pkg::PORT_DATA, wr, d);
		@(negedge clock_i);
		q = rdata_i;
	endtask

	// A device access is only meaningful after its number is selected.
	task automatic dev(input logic [7:0] ldn);
		logic [7:0] q;
		acc(acfg_pkg::IDX_LDN, 1'b1, ldn, q);
	endtask
endmodule
`default_nettype wire

// file: dv/acfg_bank_bench.sv
// Self-checking bench for the configuration bank.
`timescale 1ns/1ps
`default_nettype none
module acfg_bank_bench;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic hard_rst_i = 1'b0;
	logic vcc_por_i = 1'b0;
	logic vtr_por_i = 1'b0;
	logic floppy_rate_wr_i = 1'b0;
	logic serial_port_a_fcr_wr_i = 1'b0;
	logic serial_port_b_fcr_wr_i = 1'b0;
	logic [7:0] shadow_data_i = 8'h00;
	logic wdt_expired_i = 1'b0;
	logic sci_event_i = 1'b0;
	logic io_sel, io_wr, io_rd, soft_rst_o, global_config_reg_22_b5_o;
	logic wdt_status_o, wdt_force_o, sci_o, aux_active_o, pm_active_o;
	logic [7:0] io_wdata, io_rdata_o, ldn_o, pm_irq_sel_o, sleep_wake_o;
	logic [15:0] pm_block_base_o;
	int errors = 0;
	int n_compared = 0;
	int n_soft = 0;
	int n_force = 0;
	integer seed = 32'hA24F0D03;

	always #25 clock_i = ~clock_i;

	always @(posedge clock_i) begin
		if (soft_rst_o === 1'b1) n_soft <= n_soft + 1;
		if (wdt_force_o === 1'b1) n_force <= n_force + 1;
	end

	acfg_host acfg_host_inst (.clock_i(clock_i), .rdata_i(io_rdata_o), .sel_o(io_sel),
		.wr_o(io_wr), .rd_o(io_rd), .wdata_o(io_wdata));

	acfg_bank acfg_bank_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .hard_rst_i(hard_rst_i),
		.vcc_por_i(vcc_por_i), .vtr_por_i(vtr_por_i), .io_sel_i(io_sel), .io_wr_i(io_wr),
		.io_rd_i(io_rd), .io_wdata_i(io_wdata), .floppy_rate_wr_i(floppy_rate_wr_i),
		.serial_port_a_fcr_wr_i(serial_port_a_fcr_wr_i),
		.serial_port_b_fcr_wr_i(serial_port_b_fcr_wr_i), .shadow_data_i(shadow_data_i),
		.wdt_expired_i(wdt_expired_i), .sci_event_i(sci_event_i), .io_rdata_o(io_rdata_o),
		.ldn_o(ldn_o), .soft_rst_o(soft_rst_o),
		.global_config_reg_22_b5_o(global_config_reg_22_b5_o),
		.aux_active_o(aux_active_o), .pm_active_o(pm_active_o),
		.pm_block_base_o(pm_block_base_o), .pm_irq_sel_o(pm_irq_sel_o),
		.sleep_wake_o(sleep_wake_o),
		.wdt_status_o(wdt_status_o), .wdt_force_o(wdt_force_o), .sci_o(sci_o));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic report_and_stop;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		cmp_byte({7'h00, got}, {7'h00, exp});
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		acfg_host_inst.acc(idx, 1'b1, d, q);
	endtask

	task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] q;
		acfg_host_inst.acc(idx, 1'b0, 8'h00, q);
		cmp_byte(q, exp);
	endtask

	function automatic logic [7:0] ldn_of(int i);
		return (i < acfg_pkg::T_PM_ACT) ? acfg_pkg::LDN_AUX : acfg_pkg::LDN_PM;
	endfunction

	initial begin
		#1000000;
		errors++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] v [4];
		int f;
		repeat (3) @(posedge clock_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < acfg_pkg::NREG; i++) begin
			acfg_host_inst.dev(ldn_of(i));
			cmp_byte(ldn_o, ldn_of(i));
			chk(acfg_pkg::OFS[i], acfg_pkg::RSTV[i]);
			v[0] = 8'($random(seed));
			wr(acfg_pkg::OFS[i], v[0]);
			chk(acfg_pkg::OFS[i], v[0]);
			if (i == acfg_pkg::T_PM_IRQ) cmp_byte(pm_irq_sel_o, v[0]);
			if (i == acfg_pkg::T_PM_SLEEP) cmp_byte(sleep_wake_o, v[0]);
		end
		// Same index in two devices must stay apart.
		acfg_host_inst.dev(acfg_pkg::LDN_AUX);
		wr(8'h30, 8'h01);
		acfg_host_inst.dev(acfg_pkg::LDN_PM);
		wr(8'h30, 8'h00);
		cmp_bit(aux_active_o, 1'b1);
		cmp_bit(pm_active_o, 1'b0);
		acfg_host_inst.dev(8'h03);
		wr(8'h30, 8'hFF);
		chk(8'h30, 8'h00);
		cmp_bit(pm_active_o, 1'b0);
		wr(8'h01, 8'hFF);
		chk(8'h01, 8'h00);
		wr(8'h00, 8'hFF);
		chk(8'h00, 8'h00);
		acfg_host_inst.dev(acfg_pkg::LDN_AUX);
		wr(8'hB4, 8'hFF);
		chk(8'hB4, 8'h00);
		v[0] = 8'($random(seed));
		v[1] = 8'($random(seed));
		acfg_host_inst.dev(acfg_pkg::LDN_PM);
		wr(8'h60, v[0]);
		wr(8'h61, v[1]);
		cmp_byte(pm_block_base_o[15:8], v[0]);
		cmp_byte(pm_block_base_o[7:0], v[1]);
		// The event path must run while the device is inactive.
		for (int i = 0; i < 16; i++) begin
			@(posedge clock_i);
			sci_event_i <= 1'($random(seed));
			@(posedge clock_i);
			@(negedge clock_i);
			cmp_bit(sci_o, sci_event_i);
		end
		sci_event_i <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			v[i] = 8'($random(seed));
			@(posedge clock_i);
			shadow_data_i <= v[i];
			floppy_rate_wr_i <= (i == 0);
			serial_port_a_fcr_wr_i <= (i == 1);
			serial_port_b_fcr_wr_i <= (i == 2);
		end
		@(posedge clock_i);
		floppy_rate_wr_i <= 1'b0;
		serial_port_a_fcr_wr_i <= 1'b0;
		serial_port_b_fcr_wr_i <= 1'b0;
		shadow_data_i <= ~v[2];
		acfg_host_inst.dev(acfg_pkg::LDN_AUX);
		for (int i = 0; i < 3; i++) begin
			wr(acfg_pkg::SHADOW_IDX[i], ~v[i]);
			chk(acfg_pkg::SHADOW_IDX[i], v[i]);
		end
		// A read strobe in the cycle right after a capture must already see the new byte.
		v[3] = 8'($random(seed));
		fork
			chk(acfg_pkg::SHADOW_IDX[0], v[3]);
			begin
				repeat (2) @(posedge clock_i);
				floppy_rate_wr_i <= 1'b1;
				shadow_data_i <= v[3];
				@(posedge clock_i);
				floppy_rate_wr_i <= 1'b0;
			end
		join
		@(posedge clock_i);
		wdt_expired_i <= 1'b1;
		@(posedge clock_i);
		wdt_expired_i <= 1'b0;
		chk(8'hF4, 8'h01);
		cmp_bit(wdt_status_o, 1'b1);
		f = n_force;
		wr(8'hF4, 8'h02);
		repeat (3) @(posedge clock_i);
		cmp_byte(8'(n_force - f), 8'h01);
		chk(8'hF4, 8'h01);
		wr(8'hF4, 8'h04);
		chk(8'hF4, 8'h00);
		cmp_bit(wdt_status_o, 1'b0);
		for (int i = 0; i < 4; i++) v[i] = 8'($random(seed));
		wr(8'h30, 8'h01);
		wr(8'hF1, v[0]);
		wr(8'hB0, v[1]);
		wr(8'hC5, v[2]);
		acfg_host_inst.dev(acfg_pkg::LDN_PM);
		wr(8'h30, 8'h01);
		f = n_soft;
		wr(acfg_pkg::IDX_CFG_CTRL, 8'h01);
		repeat (3) @(posedge clock_i);
		cmp_byte(8'(n_soft - f), 8'h01);
		chk(acfg_pkg::IDX_CFG_CTRL, 8'h00);
		chk(8'h60, 8'h00);
		cmp_bit(pm_active_o, 1'b0);
		acfg_host_inst.dev(acfg_pkg::LDN_AUX);
		chk(8'h30, 8'h00);
		chk(8'hF1, v[0]);
		chk(8'hB0, v[1]);
		chk(8'hC5, v[2]);
		// Pin resets in turn: hard, main supply, standby supply.
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 3; i++) v[i] = 8'($random(seed));
			wr(acfg_pkg::IDX_GLOBAL_CONFIG_REG_22, 8'h20);
			acfg_host_inst.dev(acfg_pkg::LDN_AUX);
			wr(8'hC5, v[0]);
			wr(8'hF1, v[1]);
			wr(8'hB0, v[2]);
			@(posedge clock_i);
			hard_rst_i <= (k == 0);
			vcc_por_i <= (k == 1);
			vtr_por_i <= (k == 2);
			repeat (3) @(posedge clock_i);
			hard_rst_i <= 1'b0;
			vcc_por_i <= 1'b0;
			vtr_por_i <= 1'b0;
			repeat (8) @(posedge clock_i);
			cmp_bit(global_config_reg_22_b5_o, k != 2);
			chk(acfg_pkg::IDX_GLOBAL_CONFIG_REG_22, (k == 2) ? 8'h00 : 8'h20);
			acfg_host_inst.dev(acfg_pkg::LDN_AUX);
			chk(8'hC5, (k == 2) ? v[0] : 8'h00);
			chk(8'hF1, 8'h00);
			chk(8'hB0, v[2]);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
